//--- design/amdec_decoder.sv
// Purpose: Fetches prefix, opcode and operand bytes and forms the operand address.
// Assumes: Memory answers a held read with memAck and memData in one cycle or later.
// Notes: One instruction per start pulse; result stands until the next done.
// Operation
// - Inherent instructions are one byte, no operands.
// - Immediate fetches one byte used as operand.
// - Short direct uses one address byte, zero page.
// - Long direct uses two address bytes, full space.
// - Indexed address is unsigned index plus offset.
// - No-offset indexed uses index value directly.
// - Short indexed adds byte offset, reaches 1FE.
// - Long indexed adds word offset, full space.
// - Short indirect reads byte pointer in zero page.
// - Long indirect reads word pointer, full space.
// - Relative reach is -128..+127 from next instruction.
// - Read-modify-write rows use short addressing only.
// - Long variants cost extra bytes and cycles.
// - Inherent class includes wait and oscillator stop.
// - Relative adds signed byte, direct or from memory.
// - Indirect indexed adds index to fetched pointer.
// - Prefix 90 switches first index to second.
// - Prefix 92 turns direct and offset indexed into indirect.
`timescale 1ns/1ps
module amdec_decoder (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic start,
    input wire amdec_pkg::amdec_req_t req,
    input wire logic memAck,
    input wire logic [7:0] memData,
    output logic memRd_r,
    output logic [15:0] memAddr_r,
    output logic busy_r,
    output logic done_r,
    output amdec_pkg::amdec_res_t result_r
);
    import amdec_pkg::*;
    default clocking cbSys @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_OPC = 6'b000010,
        S_STRM = 6'b000100,
        S_PTR = 6'b001000,
        S_TAIL = 6'b010000,
        S_DONE = 6'b100000
    } amdec_state_t;

    amdec_state_t state_r, state_nxt;
    amdec_dec_t dec_r, dec_nxt;
    amdec_res_t result_nxt;
    logic [15:0] pc_r, pc_nxt, buf_r, buf_nxt, ptr_r, ptr_nxt, memAddr_nxt;
    logic [7:0] idxX_r, idxX_nxt, idxY_r, idxY_nxt, op_r, op_nxt, rel_r, rel_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic ind_r, ind_nxt, useY_r, useY_nxt, memRd_nxt, busy_nxt, done_nxt, ack;
    logic [15:0] base, effAddr;
    logic [7:0] idxSel, relOff;

    // Row table of the opcode map; only rows 0, 1, 3, 6 and 7 modify memory.
    function automatic amdec_dec_t decode(input logic [7:0] op, input logic ind);
        amdec_dec_t d;
        d = '0;
        d.mode = AM_INH;
        case (op[7:4])
            NIB_BITREL, NIB_BIT: begin
                d.mode = ind ? AM_BIT_I : AM_BIT;
                d.nStream = 2'd1;
                d.nPtr = {1'b0, ind};
                d.bitRel = (op[7:4] == NIB_BITREL);
                d.rmw = 1'b1;
            end
            NIB_REL: begin
                d.mode = ind ? AM_REL_I : AM_REL;
                d.nStream = 2'd1;
                d.nPtr = {1'b0, ind};
                d.relative = 1'b1;
            end
            NIB_RMW_DIR, NIB_DIR_S: begin
                d.mode = ind ? AM_IND_S : AM_DIR_S;
                d.nStream = 2'd1;
                d.nPtr = {1'b0, ind};
                d.rmw = (op[7:4] == NIB_RMW_DIR);
            end
            NIB_RMW_IDX_S, NIB_IDX_S: begin
                d.mode = ind ? AM_IIDX_S : AM_IDX_S;
                d.nStream = 2'd1;
                d.nPtr = {1'b0, ind};
                d.indexed = 1'b1;
                d.rmw = (op[7:4] == NIB_RMW_IDX_S);
            end
            NIB_RMW_IDX_0, NIB_IDX_0: begin
                d.mode = AM_IDX_0;
                d.indexed = 1'b1;
                d.rmw = (op[7:4] == NIB_RMW_IDX_0);
            end
            NIB_IMM: begin
                d.mode = AM_IMM;
                d.nStream = 2'd1;
            end
            NIB_DIR_L: begin
                d.mode = ind ? AM_IND_L : AM_DIR_L;
                d.nStream = ind ? 2'd1 : 2'd2;
                d.nPtr = ind ? 2'd2 : 2'd0;
            end
            NIB_IDX_L: begin
                d.mode = ind ? AM_IIDX_L : AM_IDX_L;
                d.nStream = ind ? 2'd1 : 2'd2;
                d.nPtr = ind ? 2'd2 : 2'd0;
                d.indexed = 1'b1;
            end
            default: d.mode = AM_INH;
        endcase
        return d;
    endfunction

    assign ack = memRd_r & memAck;

    // Address arithmetic on the collected bytes.
    always_comb begin
        base = (dec_r.nPtr != 2'd0) ? ptr_r : buf_r;
        idxSel = useY_r ? idxY_r : idxX_r;
        effAddr = dec_r.indexed ? base + {8'h00, idxSel} : base;
        relOff = dec_r.bitRel ? rel_r : base[7:0];
    end

    always_comb begin
        state_nxt = state_r;
        dec_nxt = dec_r;
        pc_nxt = pc_r;
        buf_nxt = buf_r;
        ptr_nxt = ptr_r;
        idxX_nxt = idxX_r;
        idxY_nxt = idxY_r;
        op_nxt = op_r;
        rel_nxt = rel_r;
        cnt_nxt = cnt_r;
        ind_nxt = ind_r;
        useY_nxt = useY_r;
        memAddr_nxt = memAddr_r;
        result_nxt = result_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        case (state_r)
            S_IDLE: begin
                if (start) begin
                    pc_nxt = req.pc;
                    idxX_nxt = req.idxX;
                    idxY_nxt = req.idxY;
                    ind_nxt = 1'b0;
                    useY_nxt = 1'b0;
                    memAddr_nxt = req.pc;
                    busy_nxt = 1'b1;
                    state_nxt = S_OPC;
                end
            end
            S_OPC: begin
                if (ack) begin
                    pc_nxt = pc_r + 16'h0001;
                    memAddr_nxt = pc_r + 16'h0001;
                    if (memData == PFX_ALT) begin
                        useY_nxt = 1'b1;
                    end else if (memData == PFX_IND) begin
                        ind_nxt = 1'b1;
                    end else if (memData == PFX_ALT_IND) begin
                        ind_nxt = 1'b1;
                        useY_nxt = 1'b1;
                    end else begin
                        op_nxt = memData;
                        dec_nxt = decode(memData, ind_r);
                        cnt_nxt = dec_nxt.nStream;
                        buf_nxt = '0;
                        ptr_nxt = '0;
                        rel_nxt = '0;
                        state_nxt = (dec_nxt.nStream != 2'd0) ? S_STRM : S_DONE;
                    end
                end
            end
            S_STRM: begin
                if (ack) begin
                    buf_nxt = {buf_r[7:0], memData};
                    pc_nxt = pc_r + 16'h0001;
                    memAddr_nxt = pc_r + 16'h0001;
                    cnt_nxt = cnt_r - 2'd1;
                    if (cnt_r == 2'd1) begin
                        if (dec_r.nPtr != 2'd0) begin
                            cnt_nxt = dec_r.nPtr;
                            memAddr_nxt = {8'h00, memData};
                            state_nxt = S_PTR;
                        end else begin
                            state_nxt = dec_r.bitRel ? S_TAIL : S_DONE;
                        end
                    end
                end
            end
            S_PTR: begin
                if (ack) begin
                    ptr_nxt = {ptr_r[7:0], memData};
                    memAddr_nxt = memAddr_r + 16'h0001;
                    cnt_nxt = cnt_r - 2'd1;
                    if (cnt_r == 2'd1) begin
                        memAddr_nxt = pc_r;
                        state_nxt = dec_r.bitRel ? S_TAIL : S_DONE;
                    end
                end
            end
            S_TAIL: begin
                if (ack) begin
                    rel_nxt = memData;
                    pc_nxt = pc_r + 16'h0001;
                    state_nxt = S_DONE;
                end
            end
            S_DONE: begin
                result_nxt.mode = dec_r.mode;
                result_nxt.opcode = op_r;
                result_nxt.useY = useY_r;
                result_nxt.effAddr = effAddr;
                result_nxt.operand = buf_r[7:0];
                // Counter already points past the jump here.
                result_nxt.jumpTarget = pc_r + {{8{relOff[7]}}, relOff};
                result_nxt.pcNext = pc_r;
                result_nxt.rmw = dec_r.rmw;
                result_nxt.lowPower = (dec_r.mode == AM_INH)
                    && (op_r == OP_INTERRUPT_WAIT || op_r == OP_OSC_STOP);
                done_nxt = 1'b1;
                busy_nxt = 1'b0;
                state_nxt = S_IDLE;
            end
            default: state_nxt = S_IDLE;
        endcase
        memRd_nxt = (state_nxt == S_OPC) || (state_nxt == S_STRM)
            || (state_nxt == S_PTR) || (state_nxt == S_TAIL);
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r <= S_IDLE;
            dec_r <= '0;
            pc_r <= ADDR_RESET;
            buf_r <= '0;
            ptr_r <= '0;
            idxX_r <= '0;
            idxY_r <= '0;
            op_r <= '0;
            rel_r <= '0;
            cnt_r <= '0;
            ind_r <= 1'b0;
            useY_r <= 1'b0;
            memRd_r <= 1'b0;
            memAddr_r <= ADDR_RESET;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            result_r <= '0;
        end else begin
            state_r <= state_nxt;
            dec_r <= dec_nxt;
            pc_r <= pc_nxt;
            buf_r <= buf_nxt;
            ptr_r <= ptr_nxt;
            idxX_r <= idxX_nxt;
            idxY_r <= idxY_nxt;
            op_r <= op_nxt;
            rel_r <= rel_nxt;
            cnt_r <= cnt_nxt;
            ind_r <= ind_nxt;
            useY_r <= useY_nxt;
            memRd_r <= memRd_nxt;
            memAddr_r <= memAddr_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            result_r <= result_nxt;
        end
    end

    // Checker helpers: start address and prefix count of the current instruction.
    logic [15:0] pcStart_h, len_h;
    logic [1:0] pfx_h;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pcStart_h <= '0;
            pfx_h <= '0;
        end else if (state_r == S_IDLE && start) begin
            pcStart_h <= req.pc;
            pfx_h <= '0;
        end else if (state_r == S_OPC && ack
            && memData inside {PFX_ALT, PFX_IND, PFX_ALT_IND}) begin
            pfx_h <= pfx_h + 2'd1;
        end
    end
    assign len_h = result_r.pcNext - pcStart_h - {14'd0, pfx_h};

    property p_inh_len;
        done_r && result_r.mode == AM_INH |-> len_h == 16'd1;
    endproperty
    a_inh_len: assert property (p_inh_len) else $error("inherent length wrong");

    property p_imm_len;
        done_r && result_r.mode == AM_IMM |-> len_h == 16'd2;
    endproperty
    a_imm_len: assert property (p_imm_len) else $error("immediate length wrong");

    property p_short_page;
        done_r && (result_r.mode inside {AM_DIR_S, AM_IND_S, AM_IDX_0})
            |-> result_r.effAddr[15:8] == 8'h00;
    endproperty
    a_short_page: assert property (p_short_page) else $error("short address off page");

    property p_long_len;
        done_r && (result_r.mode inside {AM_DIR_L, AM_IDX_L}) |-> len_h == 16'd3;
    endproperty
    a_long_len: assert property (p_long_len) else $error("long length wrong");

    property p_idx_short;
        done_r && result_r.mode == AM_IDX_S |-> result_r.effAddr <= SHORT_IDX_MAX;
    endproperty
    a_idx_short: assert property (p_idx_short) else $error("short index range");

    property p_rel_reach;
        done_r |-> (result_r.jumpTarget - result_r.pcNext + 16'h0080) <= 16'h00ff;
    endproperty
    a_rel_reach: assert property (p_rel_reach) else $error("relative reach wrong");

    property p_rmw_short;
        done_r && result_r.rmw
            |-> !(result_r.mode inside {AM_DIR_L, AM_IDX_L, AM_IND_L, AM_IIDX_L});
    endproperty
    a_rmw_short: assert property (p_rmw_short) else $error("long mode on rmw");

    sequence s_wait;
        memRd_r && !memAck;
    endsequence
    property p_fetch_hold;
        s_wait |=> memRd_r && $stable(memAddr_r);
    endproperty
    a_fetch_hold: assert property (p_fetch_hold) else $error("fetch dropped");
endmodule

//--- design/amdec_pkg.sv
// Purpose: Shared constants and types for the operand addressing decoder.
// Assumes: Byte-wide program and data memory shared on one read port.
// Notes: Opcode rows are grouped by the high nibble of the opcode.
package amdec_pkg;
    localparam logic [7:0] PFX_ALT = 8'h90;
    localparam logic [7:0] PFX_IND = 8'h92;
    localparam logic [7:0] PFX_ALT_IND = 8'h91;
    localparam logic [7:0] OP_INTERRUPT_WAIT = 8'h8f;
    localparam logic [7:0] OP_OSC_STOP = 8'h8e;
    localparam logic [3:0] NIB_BITREL = 4'h0;
    localparam logic [3:0] NIB_BIT = 4'h1;
    localparam logic [3:0] NIB_REL = 4'h2;
    localparam logic [3:0] NIB_RMW_DIR = 4'h3;
    localparam logic [3:0] NIB_RMW_IDX_S = 4'h6;
    localparam logic [3:0] NIB_RMW_IDX_0 = 4'h7;
    localparam logic [3:0] NIB_IMM = 4'ha;
    localparam logic [3:0] NIB_DIR_S = 4'hb;
    localparam logic [3:0] NIB_DIR_L = 4'hc;
    localparam logic [3:0] NIB_IDX_L = 4'hd;
    localparam logic [3:0] NIB_IDX_S = 4'he;
    localparam logic [3:0] NIB_IDX_0 = 4'hf;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [15:0] SHORT_IDX_MAX = 16'h01fe;

    typedef enum logic [3:0] {
        AM_INH, AM_IMM, AM_DIR_S, AM_DIR_L, AM_IDX_0, AM_IDX_S, AM_IDX_L, AM_IND_S,
        AM_IND_L, AM_IIDX_S, AM_IIDX_L, AM_REL, AM_REL_I, AM_BIT, AM_BIT_I
    } amdec_mode_t;

    typedef struct packed {
        amdec_mode_t mode;
        logic [1:0] nStream;
        logic [1:0] nPtr;
        logic indexed;
        logic relative;
        logic bitRel;
        logic rmw;
    } amdec_dec_t;

    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] idxX;
        logic [7:0] idxY;
    } amdec_req_t;

    typedef struct packed {
        amdec_mode_t mode;
        logic [7:0] opcode;
        logic useY;
        logic [15:0] effAddr;
        logic [7:0] operand;
        logic [15:0] jumpTarget;
        logic [15:0] pcNext;
        logic rmw;
        logic lowPower;
    } amdec_res_t;
endpackage

//--- verif/amdec_mem_model.sv
// Purpose: Behavioural program and data memory that answers the decoder's read port.
// Assumes: One byte per read; the answer comes after lat idle cycles per byte.
// Notes: Outside an answer the data lines show the inverse of the last byte returned.
`timescale 1ns/1ps
module amdec_mem_model (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic memRd,
    input wire logic [15:0] memAddr,
    input wire logic [3:0] lat,
    output logic memAck,
    output logic [7:0] memData,
    output logic [15:0] rdCnt
);
    logic [7:0] mem [0:65535];
    logic [3:0] waitCnt;
    logic [7:0] lastByte;

    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'h00;
        end
    end

    assign memAck = memRd && (waitCnt >= lat);
    // Unanswered cycles must not look like valid data.
    assign memData = memAck ? mem[memAddr] : ~lastByte;

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            waitCnt <= 4'h0;
            lastByte <= 8'h00;
            rdCnt <= 16'h0000;
        end else if (memAck) begin
            waitCnt <= 4'h0;
            lastByte <= mem[memAddr];
            rdCnt <= rdCnt + 16'h0001;
        end else if (memRd) begin
            waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule

//--- verif/tb.sv
// Purpose: Self-checking bench for the operand addressing decoder.
// Assumes: Memory model answers promptly or after a set number of wait cycles.
// Notes: Each scenario decodes instructions placed in memory, the slow one reusing an earlier one, and judges the result.
`timescale 1ns/1ps
module tb;
    import amdec_pkg::*;
    logic clk_sys;
    logic sys_rst;
    logic start;
    amdec_req_t req;
    logic memAck;
    logic [7:0] memData;
    logic memRd_r;
    logic [15:0] memAddr_r;
    logic busy_r;
    logic done_r;
    amdec_res_t result_r;
    logic [3:0] lat;
    logic [15:0] rdCnt;
    logic [15:0] nRd;
    int cyc;
    int cycRef;
    int error_cnt;
    int cmp_count;

    amdec_decoder amdec_decoder_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .start(start),
        .req(req), .memAck(memAck), .memData(memData), .memRd_r(memRd_r),
        .memAddr_r(memAddr_r), .busy_r(busy_r), .done_r(done_r), .result_r(result_r));
    amdec_mem_model amdec_mem_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .memRd(memRd_r), .memAddr(memAddr_r), .lat(lat), .memAck(memAck),
        .memData(memData), .rdCnt(rdCnt));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask

    task automatic put(input logic [15:0] a, input logic [7:0] b[$]);
        foreach (b[i]) begin
            amdec_mem_model_inst.mem[a + 16'(i)] = b[i];
        end
    endtask

    // Decodes one instruction at pc and records bytes read and cycles taken.
    task automatic run(input logic [15:0] pc, input logic [7:0] x, input logic [7:0] y);
        logic [15:0] c0;
        c0 = rdCnt;
        @(negedge clk_sys);
        req = '{pc: pc, idxX: x, idxY: y};
        start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        chk({15'h0, busy_r}, 16'h0001);
        cyc = 1;
        while (done_r !== 1'b1 && cyc < 300) begin
            @(negedge clk_sys);
            cyc++;
        end
        if (done_r !== 1'b1) begin
            $display("ERROR at %0t: got %h expected %h", $time, done_r, 1'b1);
            error_cnt++;
            give_verdict();
        end
        chk({15'h0, busy_r}, 16'h0000);
        nRd = rdCnt - c0;
    endtask

    task automatic t_inherent();
        put(16'h0100, '{8'h8f, 8'h8e});
        put(16'h0102, '{8'h90, 8'h93});
        run(16'h0100, 8'h00, 8'h00);
        chk({12'h0, result_r.mode}, {12'h0, AM_INH});
        chk(nRd, 16'h0001);
        chk(result_r.pcNext, 16'h0101);
        chk({15'h0, result_r.lowPower}, 16'h0001);
        run(16'h0101, 8'h00, 8'h00);
        chk({15'h0, result_r.lowPower}, 16'h0001);
        run(16'h0102, 8'h00, 8'h00);
        chk({15'h0, result_r.useY}, 16'h0001);
        chk(result_r.pcNext, 16'h0104);
        chk({15'h0, result_r.lowPower}, 16'h0000);
    endtask

    task automatic t_immediate();
        put(16'h0110, '{8'ha6, 8'h55});
        run(16'h0110, 8'h00, 8'h00);
        chk({8'h0, result_r.operand}, 16'h0055);
        chk({8'h0, result_r.opcode}, 16'h00a6);
        chk(nRd, 16'h0002);
        chk(result_r.pcNext, 16'h0112);
        chk({15'h0, result_r.useY}, 16'h0000);
    endtask

    task automatic t_direct();
        logic [15:0] nShort;
        put(16'h0120, '{8'hb6, 8'h80});
        put(16'h0130, '{8'hc6, 8'h12, 8'h34});
        run(16'h0120, 8'h00, 8'h00);
        chk(result_r.effAddr, 16'h0080);
        nShort = nRd;
        cycRef = cyc;
        run(16'h0130, 8'h00, 8'h00);
        chk(result_r.effAddr, 16'h1234);
        chk(nRd, nShort + 16'h0001);
        chk({15'h0, cyc > cycRef}, 16'h0001);
        chk(result_r.pcNext, 16'h0133);
        chk({15'h0, result_r.rmw}, 16'h0000);
        cycRef = cyc;
    endtask

    task automatic t_indexed();
        put(16'h0140, '{8'hf6});
        put(16'h0150, '{8'he6, 8'hff});
        put(16'h0160, '{8'hd6, 8'h12, 8'h00});
        run(16'h0140, 8'hff, 8'h00);
        chk(result_r.effAddr, 16'h00ff);
        chk(nRd, 16'h0001);
        run(16'h0150, 8'hff, 8'h00);
        chk(result_r.effAddr, 16'h01fe);
        run(16'h0160, 8'h34, 8'h00);
        chk(result_r.effAddr, 16'h1234);
        chk(result_r.pcNext, 16'h0163);
    endtask

    task automatic t_prefix_alt();
        put(16'h0170, '{8'h90, 8'he6, 8'h10});
        run(16'h0170, 8'h77, 8'h05);
        chk(result_r.effAddr, 16'h0015);
        chk({15'h0, result_r.useY}, 16'h0001);
        chk({8'h0, result_r.opcode}, 16'h00e6);
        chk(result_r.pcNext, 16'h0173);
    endtask

    task automatic t_indirect();
        put(16'h0040, '{8'h77, 8'hcd});
        put(16'h0180, '{8'h92, 8'hb6, 8'h40});
        put(16'h0190, '{8'h92, 8'hc6, 8'h40});
        put(16'h01a0, '{8'h92, 8'he6, 8'h40});
        put(16'h01f0, '{8'h91, 8'hd6, 8'h40});
        run(16'h0180, 8'h00, 8'h00);
        chk(result_r.effAddr, 16'h0077);
        chk({12'h0, result_r.mode}, {12'h0, AM_IND_S});
        run(16'h0190, 8'h00, 8'h00);
        chk(result_r.effAddr, 16'h77cd);
        chk(nRd, 16'h0005);
        run(16'h01a0, 8'h03, 8'h00);
        chk(result_r.effAddr, 16'h007a);
        chk(result_r.pcNext, 16'h01a3);
        run(16'h01f0, 8'h00, 8'h03);
        chk(result_r.effAddr, 16'h77d0);
        chk({12'h0, result_r.mode}, {12'h0, AM_IIDX_L});
        chk({15'h0, result_r.useY}, 16'h0001);
    endtask

    task automatic t_relative();
        put(16'h01b0, '{8'h20, 8'h80});
        put(16'h01c0, '{8'h20, 8'h7f});
        put(16'h01e0, '{8'h92, 8'h27, 8'h40});
        run(16'h01b0, 8'h00, 8'h00);
        chk(result_r.jumpTarget, 16'h0132);
        chk(result_r.pcNext, 16'h01b2);
        run(16'h01c0, 8'h00, 8'h00);
        chk(result_r.jumpTarget, 16'h0241);
        run(16'h01e0, 8'h00, 8'h00);
        chk({12'h0, result_r.mode}, {12'h0, AM_REL_I});
        chk(result_r.jumpTarget, 16'h025a);
        chk(nRd, 16'h0004);
    endtask

    task automatic t_rmw();
        put(16'h01d0, '{8'h3c, 8'h90});
        run(16'h01d0, 8'h00, 8'h00);
        chk({15'h0, result_r.rmw}, 16'h0001);
        chk(result_r.effAddr, 16'h0090);
    endtask

    task automatic t_bit();
        put(16'h0040, '{8'h77});
        put(16'h0200, '{8'h00, 8'h50, 8'h05});
        put(16'h0210, '{8'h92, 8'h01, 8'h40, 8'hfe});
        put(16'h0220, '{8'h1e, 8'h60});
        run(16'h0200, 8'h00, 8'h00);
        chk(result_r.effAddr, 16'h0050);
        chk(result_r.jumpTarget, 16'h0208);
        chk(result_r.pcNext, 16'h0203);
        run(16'h0210, 8'h00, 8'h00);
        chk({12'h0, result_r.mode}, {12'h0, AM_BIT_I});
        chk(result_r.effAddr, 16'h0077);
        chk(result_r.jumpTarget, 16'h0212);
        chk(nRd, 16'h0005);
        run(16'h0220, 8'h00, 8'h00);
        chk({15'h0, result_r.rmw}, 16'h0001);
        chk(result_r.pcNext, 16'h0222);
    endtask

    task automatic t_slow();
        lat = 4'h3;
        run(16'h0130, 8'h00, 8'h00);
        chk(result_r.effAddr, 16'h1234);
        chk(nRd, 16'h0003);
        chk({15'h0, cyc > cycRef}, 16'h0001);
        lat = 4'h0;
    endtask

    initial begin
        error_cnt = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        start = 1'b0;
        req = '0;
        lat = 4'h0;
        repeat (4) @(negedge clk_sys);
        sys_rst = 1'b0;
        t_inherent();
        t_immediate();
        t_direct();
        t_indexed();
        t_prefix_alt();
        t_indirect();
        t_relative();
        t_rmw();
        t_bit();
        t_slow();
        give_verdict();
    end
endmodule
